// File: rtl/urxe_pkg.sv
// Constants shared by the receive endpoint control and status block.
// Assumes a 32-bit register bus with one 16-bit register in the low half of each word.
package urxe_pkg;
   // Register byte offsets on the bus
   localparam logic [7:0] URXE_OFF_DEV_CSR = 8'h00;
   localparam logic [7:0] URXE_OFF_HOST_CSR = 8'h04;
   localparam logic [7:0] URXE_OFF_IRQ_STATUS = 8'h08;
   localparam logic [7:0] URXE_OFF_IRQ_CLEAR = 8'h0C;
   localparam logic [7:0] URXE_OFF_IRQ_ENABLE = 8'h10;
   // Control/status field positions; ISO device view only, TWE and TOG host view only
   localparam int URXE_B_ISO = 14;
   localparam int URXE_B_DMA = 13;
   localparam int URXE_B_NYET = 12;
   localparam int URXE_B_TWE = 10;
   localparam int URXE_B_TOG = 9;
   localparam int URXE_B_TRST = 7;
   localparam int URXE_B_STALL = 6;
   localparam int URXE_B_REQ = 5;
   localparam int URXE_B_FLUSH = 4;
   localparam int URXE_B_CRC = 3;
   localparam int URXE_B_OVR = 2;
   localparam int URXE_B_FULL = 1;
   localparam int URXE_B_RDY = 0;
   // Interrupt status bit positions
   localparam int URXE_IRQ_W = 5;
   localparam int URXE_I_RDY = 0;
   localparam int URXE_I_STALL_SENT = 1;
   localparam int URXE_I_OVERRUN = 2;
   localparam int URXE_I_RX_STALL = 3;
   localparam int URXE_I_ERROR = 4;
   // Handshake codes toward the packet engine
   localparam logic [1:0] URXE_HS_ACK = 2'h0;
   localparam logic [1:0] URXE_HS_NAK = 2'h1;
   localparam logic [1:0] URXE_HS_NYET = 2'h2;
   localparam logic [1:0] URXE_HS_STALL = 2'h3;
   // Bus responses
   localparam logic [1:0] URXE_RESP_OKAY = 2'h0;
   localparam logic [1:0] URXE_RESP_SLVERR = 2'h2;
   // Reset value of every register and of idle read data
   localparam logic [31:0] URXE_ZERO_WORD = 32'h0000_0000;
   // Byte lanes holding the 16-bit registers
   localparam int URXE_LANE_LO = 0;
   localparam int URXE_LANE_HI = 1;
endpackage

// File: rtl/urxe_rx_endpoint_ctrl.sv
// Receive endpoint control and status: register views, handshake choice, interrupts.
// Assumes a packet engine that reports each finished data phase as a one-cycle pulse,
// and an AXI4-Lite master on the register side; one clock, synchronous reset.
//
// Overview of operation
// [RQ1] Bit 14 selects isochronous versus bulk handling
// [RQ2] DMA request only while bit 13 set
// [RQ3] Bit 12 set: ACK always, never NYET
// [RQ4] NYET suppression matters only at high speed
// [RQ5] Bit 7 write clears toggle, reads zero
// [RQ6] STALL sent: flag, flush, drop packet ready
// [RQ7] Bit 5 held high answers with STALL
// [RQ8] Stall request ignored for isochronous endpoint
// [RQ9] Bit 4 drops next packet, clears ready
// [RQ10] Flush ignored unless packet ready is set
// [RQ11] CRC error flag follows packet ready
// [RQ12] Error and overrun read zero in bulk
// [RQ13] Unstorable OUT packet sets sticky overrun
// [RQ14] Full flag shows no room, read only
// [RQ15] Packet received sets ready and interrupts
// [RQ16] Host toggle write enable self clears
// [RQ17] Host bit 9 shows toggle, gated write
// [RQ18] Host bit 5 requests IN, clears on ready
// [RQ19] Software writes zero to clear flags
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module urxe_rx_endpoint_ctrl
   import urxe_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int FIFO_PACKETS = 2
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic HOST_MODE,
   input wire logic HIGH_SPEED,
   input wire logic PKT_DONE,
   input wire logic PKT_CRC_ERR,
   input wire logic STALL_RECEIVED,
   input wire logic NAK_TIMEOUT,
   input wire logic NO_RESPONSE,
   output logic HS_VALID,
   output logic [1:0] HS_CODE,
   output logic FIFO_FLUSH,
   output logic IN_REQUEST,
   output logic TOGGLE_STATE,
   output logic ISO_MODE,
   output logic RX_BUFFER_FULL,
   output logic DMA_REQ,
   output logic IRQ
);
   // Packet slot counter width
   // One spare value keeps full distinct from empty
   localparam int CNT_W = $clog2(FIFO_PACKETS + 1);
   localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(FIFO_PACKETS);
   localparam logic [CNT_W-1:0] ONE_C = CNT_W'(1);
   localparam logic [CNT_W-1:0] EMPTY_C = CNT_W'(0);

   // Whole state of the block
   typedef struct packed {
      logic aw_held;                 // Write address captured
      logic [ADDR_W-1:0] aw_addr;
      logic w_held;                  // Write data captured
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic iso;                     // Isochronous handling
      logic dma_en;                  // DMA request enable
      logic nyet_off;                // Suppress NYET handshakes
      logic stall_req;               // Device stall request
      logic stall_sent;              // Device STALL went out
      logic overrun;                 // Packet could not be stored
      logic crc_err;                 // Presented packet had CRC/stuff error
      logic ready;                   // Packet ready for software
      logic toggle;                  // Receive data toggle
      logic rx_stall;                // Host saw a STALL
      logic in_req;                  // Host IN request pending
      logic nak_to;                  // Host bulk NAK timeout
      logic error;                   // Host no-response error
      logic [CNT_W-1:0] count;       // Packets held in the FIFO
      logic [URXE_IRQ_W-1:0] irq_status;
      logic [URXE_IRQ_W-1:0] irq_enable;
      logic hs_valid;
      logic [1:0] hs_code;
      logic flush;
      logic dma_req;
      logic irq;
      logic full;
   } urxe_state_s;

   urxe_state_s s;
   urxe_state_s next_s;

   // Next state: bus first, then link events so hardware sets win over clears
   always_comb begin
      logic [15:0] wd;
      logic lo;
      logic hi;
      logic wr_fire;
      logic dev_hit;
      logic host_hit;
      logic stall_on;
      logic [URXE_IRQ_W-1:0] ev;
      logic [15:0] dev_view;
      logic [15:0] host_view;
      wd = s.w_data[15:0];
      lo = s.w_strb[URXE_LANE_LO];
      hi = s.w_strb[URXE_LANE_HI];
      wr_fire = s.aw_held && s.w_held && !s.bvalid;
      // Only the low address byte is decoded
      dev_hit = wr_fire && (s.aw_addr[7:0] == URXE_OFF_DEV_CSR);
      host_hit = wr_fire && (s.aw_addr[7:0] == URXE_OFF_HOST_CSR);
      stall_on = s.stall_req && !s.iso;  // [RQ8]
      ev = '0;
      // Views start at zero so reserved bits read zero
      dev_view = '0;
      host_view = '0;
      next_s = s;
      next_s.hs_valid = 1'b0;
      next_s.flush = 1'b0;

      // Capture address and data independently, in either order
      if (S_AXI_AWVALID && s.awready) begin
         next_s.aw_held = 1'b1;
         next_s.aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && s.wready) begin
         next_s.w_held = 1'b1;
         next_s.w_data = S_AXI_WDATA;
         next_s.w_strb = S_AXI_WSTRB;
      end
      // Write response after both halves are in
      if (wr_fire) begin
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.bvalid = 1'b1;
         case (s.aw_addr[7:0])
            URXE_OFF_DEV_CSR, URXE_OFF_HOST_CSR, URXE_OFF_IRQ_CLEAR,
            URXE_OFF_IRQ_ENABLE: next_s.bresp = URXE_RESP_OKAY;
            default: next_s.bresp = URXE_RESP_SLVERR;
         endcase
      end else if (s.bvalid && S_AXI_BREADY) begin
         next_s.bvalid = 1'b0;
      end

      // Fields common to both views, high byte
      if ((dev_hit || host_hit) && hi) begin
         next_s.dma_en = wd[URXE_B_DMA];                   // [RQ2]
         next_s.nyet_off = wd[URXE_B_NYET];                // [RQ3]
      end
      // Device-only high byte
      if (dev_hit && hi) begin
         next_s.iso = wd[URXE_B_ISO];                      // [RQ1]
      end
      // Host toggle write: enable is a strobe that never stays set
      // Not stored, so the enable always reads zero
      if (host_hit && hi && wd[URXE_B_TWE]) begin
         next_s.toggle = wd[URXE_B_TOG];                   // [RQ16] [RQ17]
      end
      // Low byte, both views
      if ((dev_hit || host_hit) && lo) begin
         if (wd[URXE_B_TRST]) begin
            next_s.toggle = 1'b0;                          // [RQ5]
         end
         // Each drop removes one packet; the next shows at the same edge
         // Flush drops only a presented packet
         if (wd[URXE_B_FLUSH] && s.ready) begin            // [RQ10]
            next_s.count = s.count - ONE_C;                // [RQ9]
            next_s.ready = 1'b0;
            next_s.crc_err = 1'b0;
            next_s.flush = 1'b1;
         end else if (!wd[URXE_B_RDY] && s.ready) begin
            // Ready written low: packet unloaded
            next_s.count = s.count - ONE_C;                // [RQ19]
            next_s.ready = 1'b0;
            next_s.crc_err = 1'b0;                         // [RQ11]
         end
      end
      // Device low byte
      if (dev_hit && lo) begin
         next_s.stall_sent = s.stall_sent && wd[URXE_B_STALL];
         next_s.stall_req = wd[URXE_B_REQ];                // [RQ7]
         next_s.overrun = s.overrun && wd[URXE_B_OVR];     // [RQ13]
      end
      // Host low byte
      if (host_hit && lo) begin
         next_s.rx_stall = s.rx_stall && wd[URXE_B_STALL];
         next_s.nak_to = s.nak_to && wd[URXE_B_CRC];
         next_s.error = s.error && wd[URXE_B_OVR];
         if (wd[URXE_B_REQ]) begin
            next_s.in_req = 1'b1;                          // [RQ18]
         end
      end
      // Interrupt clear and enable
      // Clear is write-one per bit; enable is a copy
      if (wr_fire && lo && s.aw_addr[7:0] == URXE_OFF_IRQ_CLEAR) begin
         next_s.irq_status = s.irq_status & ~wd[URXE_IRQ_W-1:0];
      end
      if (wr_fire && lo && s.aw_addr[7:0] == URXE_OFF_IRQ_ENABLE) begin
         next_s.irq_enable = wd[URXE_IRQ_W-1:0];
      end

      // Finished data phase from the bus partner
      if (PKT_DONE) begin
         if (!HOST_MODE && stall_on) begin
            // Answer with STALL and drop everything held
            // Answered at the data phase, not the token
            next_s.hs_valid = 1'b1;
            next_s.hs_code = URXE_HS_STALL;                // [RQ7]
            next_s.stall_sent = 1'b1;                      // [RQ6]
            next_s.count = EMPTY_C;
            next_s.ready = 1'b0;
            next_s.crc_err = 1'b0;
            next_s.flush = 1'b1;
            ev[URXE_I_STALL_SENT] = 1'b1;
         end else if (PKT_CRC_ERR && !s.iso) begin
            // Corrupt bulk packet: silently discarded, partner retries
            next_s.hs_valid = 1'b0;
         end else if (next_s.count == DEPTH_C) begin
            // No room left for this packet
            if (s.iso) begin
               next_s.overrun = 1'b1;                      // [RQ13]
               ev[URXE_I_OVERRUN] = 1'b1;
            end else if (!HOST_MODE) begin
               // Partner retries once software makes room
               next_s.hs_valid = 1'b1;
               next_s.hs_code = URXE_HS_NAK;
            end
         end else begin
            // Store the packet
            next_s.count = next_s.count + ONE_C;
            // Limitation: a queued packet loses its error mark
            if (s.iso && PKT_CRC_ERR && !next_s.ready) begin
               next_s.crc_err = 1'b1;                      // [RQ11]
            end
            if (!s.iso) begin
               next_s.toggle = !next_s.toggle;             // [RQ1]
               if (!HOST_MODE) begin
                  next_s.hs_valid = 1'b1;
                  // NYET only at high speed when this packet fills the FIFO
                  if (HIGH_SPEED && !s.nyet_off && next_s.count == DEPTH_C) begin // [RQ4]
                     next_s.hs_code = URXE_HS_NYET;
                  end else begin
                     next_s.hs_code = URXE_HS_ACK;         // [RQ3]
                  end
               end
            end
         end
      end
      // Host-side link events
      // Timeouts and retries exist for bulk only
      if (HOST_MODE && STALL_RECEIVED) begin
         next_s.rx_stall = 1'b1;
         ev[URXE_I_RX_STALL] = 1'b1;
      end
      if (HOST_MODE && NAK_TIMEOUT && !s.iso) begin
         next_s.nak_to = 1'b1;
         ev[URXE_I_ERROR] = 1'b1;
      end
      if (HOST_MODE && NO_RESPONSE && !s.iso) begin
         next_s.error = 1'b1;
         ev[URXE_I_ERROR] = 1'b1;
      end
      // Present the next held packet to software
      if (!next_s.ready && next_s.count != EMPTY_C) begin
         next_s.ready = 1'b1;                              // [RQ15]
         next_s.in_req = 1'b0;                             // [RQ18]
         ev[URXE_I_RDY] = 1'b1;
      end
      // Sticky status; a new event beats a same-cycle clear
      next_s.irq_status = next_s.irq_status | ev;
      next_s.irq = |(next_s.irq_status & next_s.irq_enable);
      next_s.full = (next_s.count == DEPTH_C);             // [RQ14]
      next_s.dma_req = next_s.dma_en && next_s.ready;      // [RQ2]

      // Register views; write-only bits read zero
      dev_view[URXE_B_ISO] = s.iso;
      dev_view[URXE_B_DMA] = s.dma_en;
      dev_view[URXE_B_NYET] = s.nyet_off;
      dev_view[URXE_B_STALL] = s.stall_sent;
      dev_view[URXE_B_REQ] = s.stall_req;
      dev_view[URXE_B_CRC] = s.iso && s.crc_err;          // [RQ12]
      dev_view[URXE_B_OVR] = s.iso && s.overrun;          // [RQ12]
      dev_view[URXE_B_FULL] = s.full;
      dev_view[URXE_B_RDY] = s.ready;
      host_view[URXE_B_DMA] = s.dma_en;
      host_view[URXE_B_NYET] = s.nyet_off;
      host_view[URXE_B_TOG] = s.toggle;                   // [RQ17]
      host_view[URXE_B_STALL] = s.rx_stall;
      host_view[URXE_B_REQ] = s.in_req;
      host_view[URXE_B_CRC] = s.iso ? s.crc_err : s.nak_to;
      host_view[URXE_B_OVR] = !s.iso && s.error;
      host_view[URXE_B_FULL] = s.full;
      host_view[URXE_B_RDY] = s.ready;

      // Read channel: one answer per address
      // Data comes from state before this edge
      if (S_AXI_ARVALID && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = URXE_RESP_OKAY;
         next_s.rdata = URXE_ZERO_WORD;
         case (S_AXI_ARADDR[7:0])
            URXE_OFF_DEV_CSR: next_s.rdata[15:0] = dev_view;
            URXE_OFF_HOST_CSR: next_s.rdata[15:0] = host_view;
            URXE_OFF_IRQ_STATUS: next_s.rdata[URXE_IRQ_W-1:0] = s.irq_status;
            URXE_OFF_IRQ_ENABLE: next_s.rdata[URXE_IRQ_W-1:0] = s.irq_enable;
            URXE_OFF_IRQ_CLEAR: next_s.rdata = URXE_ZERO_WORD;
            default: next_s.rresp = URXE_RESP_SLVERR;
         endcase
      end else if (s.rvalid && S_AXI_RREADY) begin
         next_s.rvalid = 1'b0;
      end
      // Ready flags: accept only with a free holding slot
      // Low while a response waits: one transfer at a time
      next_s.awready = !next_s.aw_held && !next_s.bvalid;
      next_s.wready = !next_s.w_held && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
   end

   // Single state register, synchronous reset
   // Whole struct clears, so outputs start low
   always_ff @(posedge CLK) begin
      if (RESET) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Every output straight from the state register
   // No logic after the flops, so no glitches
   assign S_AXI_AWREADY = s.awready;
   assign S_AXI_WREADY = s.wready;
   assign S_AXI_BRESP = s.bresp;
   assign S_AXI_BVALID = s.bvalid;
   assign S_AXI_ARREADY = s.arready;
   assign S_AXI_RDATA = s.rdata;
   assign S_AXI_RRESP = s.rresp;
   assign S_AXI_RVALID = s.rvalid;
   assign HS_VALID = s.hs_valid;
   assign HS_CODE = s.hs_code;
   assign FIFO_FLUSH = s.flush;
   assign IN_REQUEST = s.in_req;
   assign TOGGLE_STATE = s.toggle;
   assign ISO_MODE = s.iso;
   assign RX_BUFFER_FULL = s.full;
   assign DMA_REQ = s.dma_req;
   assign IRQ = s.irq;
endmodule
`default_nettype wire

// File: verif/urxe_link_model.sv
// Packet engine stand-in: pulses per-packet and host events into the endpoint.
// Assumes callers run one task at a time, on the same clock as the block.
`timescale 1ns/1ps
`default_nettype none
module urxe_link_model (
   input wire logic clk,
   input wire logic hs_valid,
   input wire logic [1:0] hs_code,
   output logic pkt_done,
   output logic pkt_crc_err,
   output logic stall_rx,
   output logic nak_to,
   output logic no_resp
);
   // Idle levels before any traffic
   initial begin
      pkt_done = 1'b0;
      pkt_crc_err = 1'b0;
      stall_rx = 1'b0;
      nak_to = 1'b0;
      no_resp = 1'b0;
   end
   // One packet, after gap idle cycles; returns the handshake seen next cycle
   task automatic send(input int gap, input logic crc, output logic v, output logic [1:0] c);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      pkt_done <= 1'b1;
      pkt_crc_err <= crc;
      @(posedge clk);
      pkt_done <= 1'b0;
      // Error line is only qualified by the pulse, so show a stale inverse
      pkt_crc_err <= ~crc;
      #1;
      v = hs_valid;
      c = hs_code;
   endtask
   // Host side events: 0 stall seen, 1 NAK limit, 2 no answer
   task automatic evt(input int k);
      @(posedge clk);
      stall_rx <= (k == 0);
      nak_to <= (k == 1);
      no_resp <= (k == 2);
      @(posedge clk);
      stall_rx <= 1'b0;
      nak_to <= 1'b0;
      no_resp <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: verif/urxe_props.sv
// Port-level checks for the receive endpoint block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module urxe_props
   import urxe_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic HOST_MODE,
   input wire logic HIGH_SPEED,
   input wire logic PKT_DONE,
   input wire logic HS_VALID,
   input wire logic [1:0] HS_CODE,
   input wire logic FIFO_FLUSH,
   input wire logic ISO_MODE,
   input wire logic RX_BUFFER_FULL,
   input wire logic DMA_REQ
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   // A STALL handshake leaving the endpoint
   sequence s_stall_hs;
      HS_VALID && (HS_CODE == URXE_HS_STALL);
   endsequence
   // Both write halves taken at one edge
   sequence s_wr_taken;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   a_hs_cause: assert property (HS_VALID |-> $past(PKT_DONE) && !$past(HOST_MODE))
      else $error("handshake without a device packet");
   a_iso_silent: assert property (PKT_DONE && ISO_MODE |=> !HS_VALID)
      else $error("isochronous packet got a handshake");
   a_nyet_speed: assert property (HS_VALID && HS_CODE == URXE_HS_NYET |-> $past(HIGH_SPEED))
      else $error("NYET sent at low speed");
   a_stall_flush: assert property (s_stall_hs |-> ##[0:1] FIFO_FLUSH)
      else $error("no flush after STALL");
   a_stall_empty: assert property (s_stall_hs |-> !RX_BUFFER_FULL && !DMA_REQ)
      else $error("buffer not emptied by STALL");
   a_wr_answer: assert property (s_wr_taken |-> ##[1:2] S_AXI_BVALID)
      else $error("write response late");
   a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read data late");
   a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped");
   a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");
endmodule
bind urxe_rx_endpoint_ctrl urxe_props u_props (.CLK(CLK), .RESET(RESET),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .HOST_MODE(HOST_MODE), .HIGH_SPEED(HIGH_SPEED), .PKT_DONE(PKT_DONE), .HS_VALID(HS_VALID),
   .HS_CODE(HS_CODE), .FIFO_FLUSH(FIFO_FLUSH), .ISO_MODE(ISO_MODE),
   .RX_BUFFER_FULL(RX_BUFFER_FULL), .DMA_REQ(DMA_REQ));
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench: register bus tasks plus packet events from the link model.
// Assumes the link model and checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import urxe_pkg::*;
;
   // Stimulus, all defined from time zero
   logic clk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, host_mode = 1'b0, high_speed = 1'b0, hv;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, d;
   logic awready, wready, bvalid, arready, rvalid, hs_valid, fifo_flush, in_request;
   logic toggle_state, iso_mode, rx_full, dma_req, irq;
   logic pkt_done, crc_err, stall_rx, nak_to, no_resp;
   logic [1:0] bresp, rresp, hs_code, r, hc;
   int err_total = 0, compares = 0;
   int flushes = 0;
   // Expected handshake as {valid, code}
   localparam logic [2:0] e_ack = 3'b100, e_nyet = 3'b110, e_stall = 3'b111, e_none = 3'b000;
   localparam logic [31:0] mk = 32'hFFFF_FFFF;
   localparam logic [7:0] dv = URXE_OFF_DEV_CSR, hs = URXE_OFF_HOST_CSR;
   localparam logic [7:0] ist = URXE_OFF_IRQ_STATUS, icl = URXE_OFF_IRQ_CLEAR;
   localparam logic [7:0] ien = URXE_OFF_IRQ_ENABLE;
   urxe_rx_endpoint_ctrl uut (.CLK(clk), .RESET(reset), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .HOST_MODE(host_mode), .HIGH_SPEED(high_speed), .PKT_DONE(pkt_done),
      .PKT_CRC_ERR(crc_err), .STALL_RECEIVED(stall_rx), .NAK_TIMEOUT(nak_to),
      .NO_RESPONSE(no_resp), .HS_VALID(hs_valid), .HS_CODE(hs_code), .FIFO_FLUSH(fifo_flush),
      .IN_REQUEST(in_request), .TOGGLE_STATE(toggle_state), .ISO_MODE(iso_mode),
      .RX_BUFFER_FULL(rx_full), .DMA_REQ(dma_req), .IRQ(irq));
   urxe_link_model lm (.clk(clk), .hs_valid(hs_valid), .hs_code(hs_code),
      .pkt_done(pkt_done), .pkt_crc_err(crc_err), .stall_rx(stall_rx), .nak_to(nak_to),
      .no_resp(no_resp));
   // 20 MHz clock
   always #25 clk = ~clk;
   // Flush pulses seen, for the drop checks
   always @(posedge clk) if (fifo_flush) flushes <= flushes + 1;
   // Single comparison, counted
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One bus transfer; each channel held until the edge that takes it
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v,
      output logic [31:0] dq, output logic [1:0] rq);
      logic pa, pw, pr;
      @(posedge clk);
      awaddr <= a;
      araddr <= a;
      wdata <= v;
      awvalid <= w;
      wvalid <= w;
      arvalid <= !w;
      bready <= w;
      rready <= !w;
      pa = 1'b1;
      pw = w;
      pr = 1'b1;
      // Values read here are those sampled at the edge just passed
      while (pr) begin
         @(posedge clk);
         if (pa && (w ? awready : arready)) begin
            awvalid <= 1'b0;
            arvalid <= 1'b0;
            pa = 1'b0;
         end
         if (pw && wready) begin
            wvalid <= 1'b0;
            pw = 1'b0;
         end
         if (w ? bvalid : rvalid) begin
            rq = w ? bresp : rresp;
            dq = rdata;
            bready <= 1'b0;
            rready <= 1'b0;
            pr = 1'b0;
         end
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      xfer(1'b1, a, v, d, r);
      chk(32'(r), 32'(URXE_RESP_OKAY));
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      xfer(1'b0, a, 32'h0000_0000, d, r);
      chk(d & m, e);
   endtask
   // Packet with varied idle gap, handshake compared
   task automatic pk(input logic crc, input logic [2:0] e);
      lm.send(compares % 3, crc, hv, hc);
      chk(32'({hv, hc & {2{hv}}}), 32'(e));
   endtask
   task automatic finish_test;
      if (err_total == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      finish_test;
   end
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      rchk(dv, 32'h0000_0000, mk);
      xfer(1'b0, 8'h14, 32'h0000_0000, d, r);
      chk({d[29:0], r}, {30'h0000_0000, URXE_RESP_SLVERR});
      wr(ien, 32'h0000_001F);
      wr(dv, 32'h0000_2000);
      pk(1'b0, e_ack);
      rchk(dv, 32'h0000_2001, mk);
      chk(32'({dma_req, irq, toggle_state}), 32'h0000_0007);
      wr(dv, 32'h0000_2081);
      chk(32'(toggle_state), 32'h0000_0000);
      pk(1'b0, e_ack);
      rchk(dv, 32'h0000_2003, mk);
      chk(32'(rx_full), 32'h0000_0001);
      wr(dv, 32'h0000_2013);
      rchk(dv, 32'h0000_2001, mk);
      wr(dv, 32'h0000_2011);
      rchk(dv, 32'h0000_2000, mk);
      chk(32'(dma_req), 32'h0000_0000);
      wr(dv, 32'h0000_2010);
      rchk(dv, 32'h0000_2000, mk);
      high_speed <= 1'b1;
      pk(1'b0, e_ack);
      pk(1'b0, e_nyet);
      wr(dv, 32'h0000_3002);
      wr(dv, 32'h0000_3000);
      pk(1'b0, e_ack);
      pk(1'b0, e_ack);
      pk(1'b1, e_none);
      pk(1'b0, 3'b101);
      wr(dv, 32'h0000_0000);
      wr(dv, 32'h0000_0000);
      high_speed <= 1'b0;
      wr(icl, 32'h0000_001F);
      pk(1'b0, e_ack);
      wr(dv, 32'h0000_0021);
      wr(ien, 32'h0000_0000);
      pk(1'b0, e_stall);
      rchk(dv, 32'h0000_0060, mk);
      chk(32'(flushes), 32'h0000_0003);
      rchk(ist, 32'h0000_0003, mk);
      chk(32'(irq), 32'h0000_0000);
      wr(ien, 32'h0000_0002);
      chk(32'(irq), 32'h0000_0001);
      wr(icl, 32'h0000_0002);
      chk(32'(irq), 32'h0000_0000);
      wr(dv, 32'h0000_0000);
      pk(1'b0, e_ack);
      rchk(dv, 32'h0000_0001, mk);
      wr(ien, 32'h0000_001F);
      wr(dv, 32'h0000_4020);
      pk(1'b1, e_none);
      rchk(dv, 32'h0000_4029, mk);
      chk(32'(iso_mode), 32'h0000_0001);
      wr(dv, 32'h0000_4020);
      rchk(dv, 32'h0000_4020, mk);
      for (int i = 0; i < 3; i++) pk(1'b0, e_none);
      rchk(dv, 32'h0000_4027, mk);
      wr(dv, 32'h0000_0005);
      rchk(dv, 32'h0000_0003, mk);
      wr(dv, 32'h0000_0000);
      wr(dv, 32'h0000_0000);
      host_mode <= 1'b1;
      wr(hs, 32'h0000_0600);
      rchk(hs, 32'h0000_0200, mk);
      wr(hs, 32'h0000_0000);
      rchk(hs, 32'h0000_0200, mk);
      wr(hs, 32'h0000_0020);
      chk(32'(in_request), 32'h0000_0001);
      pk(1'b0, e_none);
      rchk(hs, 32'h0000_0001, 32'h0000_0021);
      for (int k = 0; k < 3; k++) lm.evt(k);
      rchk(ist, 32'h0000_0019, 32'h0000_0019);
      rchk(hs, 32'h0000_004D, mk);
      finish_test;
   end
endmodule
`default_nettype wire
